/* include/lfm_pkg.sv */
// Purpose: constants and types shared by the LF initiator mode controller
// Assumes: 20 MHz system clock, synchronous pin inputs
// Notes: command codes and timing figures are plain defaults
package lfm_pkg;

    // operating states, Gray coded along sleep -> wait pll -> standby -> tx
    typedef enum logic [2:0] {
        LFM_SLEEP   = 3'h0,
        LFM_PLLWAIT = 3'h1,
        LFM_STANDBY = 3'h3,
        LFM_TX      = 3'h2,
        LFM_DIAG    = 3'h6
    } lfm_state_e;

    // host command codes arriving from the serial slave
    localparam logic [7:0] LFM_CMD_TX    = 8'h01;
    localparam logic [7:0] LFM_CMD_DIAG  = 8'h02;
    localparam logic [7:0] LFM_CMD_STOP  = 8'h03;
    localparam logic [7:0] LFM_CMD_SLEEP = 8'h04;
    localparam logic [7:0] LFM_CMD_WRCFG = 8'h10;

    // configuration register set
    localparam int LFM_CFG_WORDS = 16;
    localparam int LFM_CFG_AW = 4;
    localparam logic [7:0] LFM_CFG_RESET = 8'h00;
    // configuration word fields: phase of output 2, then one enable per driver
    localparam int LFM_CFG_PHASE_BIT = 0;
    localparam int LFM_CFG_OE_LSB = 2;
    localparam logic [1:0] LFM_DRV_ALL_ON = 2'h3;

    // digital output defaults
    localparam logic LFM_DOUT_DEFAULT = 1'b0;
    localparam logic LFM_CLKSEL_HOST = 1'b0;

    // pll lock wait: 100 us at 20 MHz
    localparam int LFM_CLK_HZ = 20_000_000;
    localparam int LFM_PLL_LOCK_US = 100;
    localparam int LFM_PLL_CYC = LFM_PLL_LOCK_US * (LFM_CLK_HZ / 1_000_000);
    localparam logic [11:0] LFM_PLL_CNT = 12'(LFM_PLL_CYC - 1);

    // clock source detect: count resonator terminal edges over the pll wait
    localparam logic [7:0] LFM_RES_EDGES = 8'h10;

endpackage : lfm_pkg

/* logic/lfm_cfg_mem.sv */
// Purpose: configuration register set storage
// Assumes: one write or one read port per cycle
// Notes: read data registered; clear wipes all words
`timescale 1ns/100ps
module lfm_cfg_mem
    import lfm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // access
    input wire logic clear_i,
    input wire logic wr_i,
    input wire logic [LFM_CFG_AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_q [LFM_CFG_WORDS];

    genvar gi;
    generate
        for (gi = 0; gi < LFM_CFG_WORDS; gi++) begin : g_word
            always_ff @(posedge sys_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    mem_q[gi] <= LFM_CFG_RESET;
                end else if (clk_en_i) begin
                    if (clear_i) begin
                        mem_q[gi] <= LFM_CFG_RESET;
                    end else if (wr_i && addr_i == LFM_CFG_AW'(gi)) begin
                        mem_q[gi] <= wdata_i;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= LFM_CFG_RESET;
        end else if (clk_en_i) begin
            rdata_o <= clear_i ? LFM_CFG_RESET : mem_q[addr_i];
        end
    end
endmodule : lfm_cfg_mem

/* logic/lfm_mode_ctrl.sv */
// Purpose: operating-mode controller of a two-driver LF initiator
// Assumes: serial slave decodes frames into cmd strobes; pins synchronous
// Notes: drivers are modelled as enable plus data per output
// Notes on behaviour
// - entering sleep resets all registers, flags and the pointer
// - asleep: antenna outputs Hi-Z, PLL off, serial activity ignored
// - rising edge on wake pin leaves sleep
// - standby: antenna outputs Hi-Z, digital outputs at defaults
// - standby: transmit chain off, serial slave accepts and replies
// - transmission: digital outputs enabled, serial slave active
// - transmission: drivers follow the active configuration set
// - diagnosis: digital outputs default, antenna drivers enabled
// - diagnosis: serial slave keeps accepting commands
// - clocked by host 2 MHz clock or resonator at 4 MHz
// - host control only via four-wire serial slave with active-low select
// - clock source detected automatically during start-up
// - PLL makes 20 MHz system clock from 2 MHz reference
`timescale 1ns/100ps
module lfm_mode_ctrl
    import lfm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // wake and clock source
    input wire logic wake_pin_i,
    input wire logic resonator_second_terminal_i,
    input wire logic pll_locked_i,
    // decoded host commands from the serial slave
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic [LFM_CFG_AW-1:0] cmd_addr_i,
    // completion from transmit chain and diagnosis
    input wire logic tx_done_i,
    input wire logic diag_done_i,
    input wire logic mod_data_i,
    // pll and serial slave control
    output logic pll_en_o,
    output logic clk_src_resonator_o,
    output logic spi_en_o,
    output logic [7:0] spi_reply_o,
    // chain and outputs
    output logic tx_chain_en_o,
    output logic diag_active_o,
    output logic digital_out_o,
    output logic digital_out_en_o,
    output logic [1:0] drv_out_o,
    output logic [1:0] drv_oe_o,
    output logic [7:0] active_cfg_o,
    output logic [2:0] state_o
);
    typedef struct packed {
        lfm_state_e st;
        logic wake_prev;
        logic res_prev;
        logic [11:0] pll_cnt;
        logic [7:0] res_edges;
        logic clk_res;
        logic [LFM_CFG_AW-1:0] ptr;
        logic pll_en;
        logic spi_en;
        logic [7:0] reply;
        logic tx_en;
        logic diag;
        logic dout;
        logic dout_en;
        logic [1:0] drv;
        logic [1:0] drv_oe;
    } lfm_ctrl_s;

    lfm_ctrl_s s_q;
    lfm_ctrl_s s_d;
    logic mem_clear;
    logic mem_wr;
    logic [7:0] cfg_rdata;
    // decoded strobes; the command ones are qualified by the slave being awake, wake_edge and res_toggle are not
    logic cmd_taken;
    logic cmd_tx;
    logic cmd_diag;
    logic cmd_stop;
    logic cmd_sleep;
    logic wake_edge;
    logic res_toggle;

    // a write borrows the read port; the active word reads back one cycle later
    // the pointer never moves, so word 0 is the only active set
    lfm_cfg_mem lfm_cfg_mem_i (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .clear_i(mem_clear),
        .wr_i(mem_wr),
        .addr_i(mem_wr ? cmd_addr_i : s_q.ptr),
        .wdata_i(cmd_data_i),
        .rdata_o(cfg_rdata)
    );

    // asleep the slave is deaf: nothing is decoded until standby
    assign cmd_taken = s_q.spi_en && cmd_valid_i;
    assign cmd_tx = cmd_taken && cmd_code_i == LFM_CMD_TX;
    assign cmd_diag = cmd_taken && cmd_code_i == LFM_CMD_DIAG;
    assign cmd_stop = cmd_taken && cmd_code_i == LFM_CMD_STOP;
    assign cmd_sleep = cmd_taken && cmd_code_i == LFM_CMD_SLEEP;
    assign mem_wr = cmd_taken && cmd_code_i == LFM_CMD_WRCFG;
    // clear held through all of sleep, so no write survives it
    assign mem_clear = s_q.st == LFM_SLEEP;
    // wake edge needs the pin seen low first; reset leaves the history low
    assign wake_edge = wake_pin_i && !s_q.wake_prev;
    assign res_toggle = resonator_second_terminal_i != s_q.res_prev;

    always_comb begin
        s_d = s_q;
        s_d.wake_prev = wake_pin_i;
        s_d.res_prev = resonator_second_terminal_i;
        case (s_q.st)
            LFM_SLEEP: begin
                // hold everything at defaults while asleep
                s_d = '0;
                s_d.st = LFM_SLEEP;
                s_d.wake_prev = wake_pin_i;
                s_d.res_prev = resonator_second_terminal_i;
                if (wake_edge) begin
                    s_d.st = LFM_PLLWAIT;
                    s_d.pll_en = 1'b1;
                    s_d.pll_cnt = LFM_PLL_CNT;
                end
            end
            LFM_PLLWAIT: begin
                // resonator toggles its second terminal; a host clock leaves it idle
                // a few stray toggles stay under the threshold and still read as host
                if (res_toggle && s_q.res_edges != LFM_RES_EDGES) begin
                    s_d.res_edges = s_q.res_edges + 8'h01;
                end
                if (s_q.pll_cnt != '0) begin
                    s_d.pll_cnt = s_q.pll_cnt - 12'h001;
                end
                if (s_q.pll_cnt == '0 && pll_locked_i) begin
                    s_d.clk_res = (s_q.res_edges == LFM_RES_EDGES);
                    s_d.st = LFM_STANDBY;
                    s_d.spi_en = 1'b1;
                end
            end
            LFM_STANDBY: begin
                s_d.tx_en = 1'b0;
                s_d.drv_oe = '0;
                s_d.dout = LFM_DOUT_DEFAULT;
                s_d.dout_en = 1'b0;
                if (cmd_tx) begin
                    s_d.st = LFM_TX;
                    s_d.tx_en = 1'b1;
                    s_d.dout_en = 1'b1;
                end else if (cmd_diag) begin
                    s_d.st = LFM_DIAG;
                    s_d.diag = 1'b1;
                    s_d.drv_oe = LFM_DRV_ALL_ON;
                end
            end
            LFM_TX: begin
                s_d.dout_en = 1'b1;
                s_d.dout = mod_data_i;
                // bit 0 picks phase of output 2, bits 3:2 enable each driver
                s_d.drv_oe = cfg_rdata[LFM_CFG_OE_LSB +: 2];
                s_d.drv = {mod_data_i ^ cfg_rdata[LFM_CFG_PHASE_BIT], mod_data_i};
                if (tx_done_i || cmd_stop) begin
                    s_d.st = LFM_STANDBY;
                    s_d.tx_en = 1'b0;
                    s_d.drv_oe = '0;
                    s_d.dout = LFM_DOUT_DEFAULT;
                    s_d.dout_en = 1'b0;
                end
            end
            LFM_DIAG: begin
                s_d.dout = LFM_DOUT_DEFAULT;
                s_d.dout_en = 1'b0;
                s_d.drv_oe = LFM_DRV_ALL_ON;
                if (diag_done_i || cmd_stop) begin
                    s_d.st = LFM_STANDBY;
                    s_d.diag = 1'b0;
                    s_d.drv_oe = '0;
                end
            end
            default: begin
                s_d = '0;
                s_d.st = LFM_SLEEP;
            end
        endcase
        // serial slave answers in standby, tx and diag
        if (cmd_taken) begin
            s_d.reply = {5'h00, s_q.st};
            if (cmd_sleep) begin
                s_d.st = LFM_SLEEP;
                s_d.spi_en = 1'b0;
                s_d.pll_en = 1'b0;
                s_d.drv_oe = '0;
                s_d.tx_en = 1'b0;
                s_d.diag = 1'b0;
                s_d.dout_en = 1'b0;
                s_d.dout = LFM_DOUT_DEFAULT;
            end
        end
    end

    // one register for all state keeps the clock-enable freeze uniform
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

    assign pll_en_o = s_q.pll_en;
    assign clk_src_resonator_o = s_q.clk_res;
    assign spi_en_o = s_q.spi_en;
    assign spi_reply_o = s_q.reply;
    assign tx_chain_en_o = s_q.tx_en;
    assign diag_active_o = s_q.diag;
    assign digital_out_o = s_q.dout;
    assign digital_out_en_o = s_q.dout_en;
    assign drv_out_o = s_q.drv;
    assign drv_oe_o = s_q.drv_oe;
    assign active_cfg_o = cfg_rdata;
    assign state_o = s_q.st;
endmodule : lfm_mode_ctrl

/* testbench/lfm_mode_ctrl_sva.sv */
// Purpose: port checks of the mode controller
// Assumes: one clock domain, async reset high
// Notes: state codes 0 sleep, 1 pll wait, 3 standby, 2 tx, 6 diag
`timescale 1ns/100ps
module lfm_mode_ctrl_sva
    import lfm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // stimulus
    input wire logic wake_pin_i,
    input wire logic pll_locked_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic tx_done_i,
    // observed
    input wire logic pll_en_o,
    input wire logic spi_en_o,
    input wire logic tx_chain_en_o,
    input wire logic digital_out_en_o,
    input wire logic [1:0] drv_oe_o,
    input wire logic [2:0] state_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_cmd(c);
        cmd_valid_i && clk_en_i && spi_en_o && cmd_code_i == c;
    endsequence
    sequence s_wake;
        state_o == 3'h0 && clk_en_i && $rose(wake_pin_i);
    endsequence
    AST_ASLEEP: assert property (state_o == 3'h0 |-> drv_oe_o == 2'h0 && !pll_en_o && !spi_en_o)
        else $error("sleep outputs wrong");
    AST_STAY_ASLEEP: assert property (state_o == 3'h0 && !$rose(wake_pin_i) |=> state_o == 3'h0)
        else $error("left sleep without wake");
    AST_WAKE: assert property (s_wake |=> state_o == 3'h1 && pll_en_o)
        else $error("wake edge not taken");
    AST_PLL_WAIT: assert property (state_o == 3'h1 && !pll_locked_i |=> state_o == 3'h1)
        else $error("standby before lock");
    AST_STANDBY: assert property (state_o == 3'h3 |->
        drv_oe_o == 2'h0 && !tx_chain_en_o && !digital_out_en_o && spi_en_o)
        else $error("standby outputs wrong");
    AST_TX: assert property (state_o == 3'h2 |-> tx_chain_en_o && digital_out_en_o && spi_en_o)
        else $error("tx outputs wrong");
    AST_DIAG: assert property (state_o == 3'h6 ##1 state_o == 3'h6 |->
        drv_oe_o == 2'h3 && !digital_out_en_o && spi_en_o)
        else $error("diag outputs wrong");
    AST_TX_CMD: assert property (state_o == 3'h3 ##0 s_cmd(LFM_CMD_TX) |=> state_o == 3'h2)
        else $error("tx command not taken");
    AST_DONE: assert property (state_o == 3'h2 && tx_done_i && clk_en_i && !cmd_valid_i
        |=> state_o == 3'h3)
        else $error("tx done not back to standby");
    AST_SLEEP_CMD: assert property (s_cmd(LFM_CMD_SLEEP) |=> state_o == 3'h0 ##1
        (state_o == 3'h0 || (state_o == 3'h1 && $past(wake_pin_i) && !$past(wake_pin_i, 2))))
        else $error("sleep command not taken");
endmodule : lfm_mode_ctrl_sva
bind lfm_mode_ctrl lfm_mode_ctrl_sva lfm_mode_ctrl_sva_i (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .clk_en_i(clk_en_i), .wake_pin_i(wake_pin_i),
    .pll_locked_i(pll_locked_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .tx_done_i(tx_done_i), .pll_en_o(pll_en_o), .spi_en_o(spi_en_o),
    .tx_chain_en_o(tx_chain_en_o), .digital_out_en_o(digital_out_en_o),
    .drv_oe_o(drv_oe_o), .state_o(state_o));

/* testbench/lfm_host_model.sv */
// Purpose: host side: wake pin, decoded commands, pll lock, resonator
// Assumes: everything changes on the falling edge
// Notes: code and data fields are inverted once released, so stale data never matches; the address is kept
`timescale 1ns/100ps
module lfm_host_model
    import lfm_pkg::*;
(
    // clock and pll power
    input wire logic sys_clk_i,
    input wire logic pll_en_i,
    // toward the controller
    output logic wake_pin_o = 1'b0,
    output logic resonator_o = 1'b0,
    output logic pll_locked_o = 1'b0,
    output logic cmd_valid_o = 1'b0,
    output logic [7:0] cmd_code_o = 8'h00,
    output logic [7:0] cmd_data_o = 8'h00,
    output logic [LFM_CFG_AW-1:0] cmd_addr_o = 4'h0
);
    int lock_cnt = 0;
    logic res_run = 1'b0;
    always @(negedge sys_clk_i) begin
        lock_cnt <= pll_en_i ? lock_cnt + 1 : 0;
        pll_locked_o <= lock_cnt > 40;
        resonator_o <= res_run ? ~resonator_o : 1'b0;
    end
    task automatic wake();
        @(negedge sys_clk_i) wake_pin_o = 1'b1;
        @(negedge sys_clk_i) wake_pin_o = 1'b0;
    endtask : wake
    task automatic send(input logic [7:0] code, input logic [7:0] data);
        @(negedge sys_clk_i);
        {cmd_valid_o, cmd_code_o, cmd_data_o, cmd_addr_o} = {1'b1, code, data, 4'h0};
        @(negedge sys_clk_i);
        {cmd_valid_o, cmd_code_o, cmd_data_o} = {1'b0, ~code, ~data};
    endtask : send
endmodule : lfm_host_model

/* testbench/lfm_mode_ctrl_tb.sv */
// Purpose: self-checking bench of the mode controller
// Assumes: host model drives commands, bench drives completions
// Notes: pll wait is the full fixed count
`timescale 1ns/100ps
module lfm_mode_ctrl_tb;
    import lfm_pkg::*;
    logic sys_clk_i = 0, reset_i = 1, tx_done = 0, diag_done = 0, mod_data = 0, clk_en = 1;
    logic wake, res, lock, cv, pll_en, src, spi_en, txc, diag, dout, dout_en;
    logic [7:0] code, data, reply, cfg;
    logic [3:0] addr;
    logic [1:0] drv, oe;
    logic [2:0] state;
    int mismatches = 0, n_compared = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    lfm_host_model lfm_host_model_i (.sys_clk_i(sys_clk_i), .pll_en_i(pll_en),
        .wake_pin_o(wake), .resonator_o(res), .pll_locked_o(lock), .cmd_valid_o(cv),
        .cmd_code_o(code), .cmd_data_o(data), .cmd_addr_o(addr));
    lfm_mode_ctrl lfm_mode_ctrl_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
        .wake_pin_i(wake), .resonator_second_terminal_i(res), .pll_locked_i(lock),
        .cmd_valid_i(cv), .cmd_code_i(code), .cmd_data_i(data), .cmd_addr_i(addr),
        .tx_done_i(tx_done), .diag_done_i(diag_done), .mod_data_i(mod_data),
        .pll_en_o(pll_en), .clk_src_resonator_o(src), .spi_en_o(spi_en), .spi_reply_o(reply),
        .tx_chain_en_o(txc), .diag_active_o(diag), .digital_out_o(dout),
        .digital_out_en_o(dout_en), .drv_out_o(drv), .drv_oe_o(oe), .active_cfg_o(cfg),
        .state_o(state));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : cyc
    task automatic t_wake(input logic resonator);
        int n = 0;
        lfm_host_model_i.res_run = resonator;
        lfm_host_model_i.send(LFM_CMD_TX, 8'h00);
        cyc(1);
        check("asleep state", 8'(state), 8'h00);
        check("asleep oe", 8'(oe), 8'h00);
        lfm_host_model_i.wake();
        check("pll on", 8'(pll_en), 8'h01);
        while (spi_en !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
        check("pll wait", 8'(n == LFM_PLL_CYC), 8'h01);
        check("standby", 8'(state), 8'h03);
        check("clock source", 8'(src), 8'(resonator));
        lfm_host_model_i.res_run = 1'b0;
    endtask : t_wake
    task automatic t_tx();
        lfm_host_model_i.send(LFM_CMD_WRCFG, 8'h0D);
        cyc(2);
        lfm_host_model_i.send(LFM_CMD_TX, 8'h00);
        cyc(1);
        check("tx state", 8'(state), 8'h02);
        check("tx chain", 8'({txc, dout_en}), 8'h03);
        check("tx reply", reply, 8'h03);
        mod_data = 1'b1;
        cyc(2);
        check("tx cfg", cfg, 8'h0D);
        check("tx oe", 8'(oe), 8'h03);
        check("tx drive", 8'(drv), 8'h01);
        check("tx dout", 8'(dout), 8'h01);
        tx_done = 1'b1;
        cyc(1);
        tx_done = 1'b0;
        cyc(1);
        check("tx end", 8'({state, oe, txc, dout_en}), 8'h30);
    endtask : t_tx
    task automatic t_diag();
        lfm_host_model_i.send(LFM_CMD_DIAG, 8'h00);
        cyc(2);
        check("diag", 8'({state, oe, diag, dout_en, dout}), 8'hDC);
        clk_en = 1'b0;
        lfm_host_model_i.send(LFM_CMD_STOP, 8'h00);
        cyc(1);
        check("frozen", 8'(state), 8'h06);
        clk_en = 1'b1;
        lfm_host_model_i.send(LFM_CMD_STOP, 8'h00);
        cyc(1);
        check("diag stop", 8'(state), 8'h03);
        check("diag reply", reply, 8'h06);
        lfm_host_model_i.send(LFM_CMD_DIAG, 8'h00);
        diag_done = 1'b1;
        cyc(1);
        diag_done = 1'b0;
        cyc(1);
        check("diag end", 8'(state), 8'h03);
    endtask : t_diag
    task automatic t_sleep();
        lfm_host_model_i.send(LFM_CMD_SLEEP, 8'h00);
        cyc(2);
        check("sleep", 8'({state, pll_en, spi_en}), 8'h00);
        check("sleep cfg", cfg, LFM_CFG_RESET);
        t_wake(1'b1);
    endtask : t_sleep
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        mismatches++;
        complete_run();
    end
    initial begin
        cyc(6);
        reset_i = 1'b0;
        t_wake(1'b0);
        t_tx();
        t_diag();
        t_sleep();
        complete_run();
    end
endmodule : lfm_mode_ctrl_tb
